// *** bench/ldc_host_model.sv ***
// host side model: register frames and readback on the decoded port
// assumes the bank samples everything on the rising sys_clk edge
`timescale 1ns/10ps
`default_nettype none
module ldc_host_model
   import ldc_pkg::*;
(
   // clock
   input wire logic sys_clk,
   // towards the bank
   output var ldc_wr_t reg_wr,
   output var logic [7:0] rd_addr,
   output var logic cs_n,
   // from the bank
   input wire logic [7:0] rd_data
);
   // idle: deselected, no strobe
   initial
   begin
      reg_wr = '0;
      rd_addr = 8'h00;
      cs_n = 1'b1;
   end
   // whole frame: select, one write, deselect last
   task automatic frame(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      cs_n <= 1'b0;
      reg_wr <= '{wr: 1'b1, addr: a, data: d};
      @(posedge sys_clk);
      reg_wr <= '{wr: 1'b0, addr: ~a, data: ~d}; // released bus shows junk
      @(posedge sys_clk);
      cs_n <= 1'b1;
   endtask : frame
   // readback: address held until the answer is taken
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge sys_clk);
      rd_addr <= a;
      repeat (2) @(posedge sys_clk);
      #1;
      d = rd_data;
   endtask : rd
endmodule : ldc_host_model
`default_nettype wire

// *** bench/ldc_props.sv ***
// checker for the display control bank, watching ldc_ctrl ports only
// assumes one sys_clk domain with synchronous active-low reset
`timescale 1ns/10ps
`default_nettype none
module ldc_props
   import ldc_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic rstn,
   // register side
   input wire ldc_wr_t reg_wr,
   input wire logic [7:0] rd_addr,
   input wire logic [7:0] rd_data,
   input wire logic cs_n,
   // display side
   input wire logic [LDC_SEG_W-1:0] upper_plane,
   input wire logic [LDC_SEG_W-1:0] lower_plane,
   input wire logic [LDC_SEG_W-1:0] seg_on,
   input wire logic display_run,
   input wire logic per_digit_intensity,
   input wire logic [LDC_DUTY_W-1:0] global_duty,
   input wire logic [LDC_SCAN_W-1:0] scan_last,
   input wire logic clear_digits,
   input wire logic blink_phase
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rstn);
   // one write to an address, not repeated on the next edge
   sequence s_wr(a);
      reg_wr.wr && reg_wr.addr == a ##1 !(reg_wr.wr && reg_wr.addr == a);
   endsequence
   // register lands one edge after the write, its output one edge later
   chk_run_bit: assert property (s_wr(LDC_ADDR_CONFIG) |=> display_run == $past(reg_wr.data[0], 2))
      else $error("run output does not follow config bit 0");
   chk_dark_off: assert property (!display_run && !$past(display_run) |-> seg_on == 16'h0000)
      else $error("segments lit in shutdown");
   chk_src_bit: assert property (s_wr(LDC_ADDR_CONFIG) |=> per_digit_intensity == $past(reg_wr.data[6], 2))
      else $error("intensity source does not follow bit 6");
   chk_scan_low: assert property (s_wr(LDC_ADDR_SCAN) |=> scan_last == $past(reg_wr.data[2:0], 2))
      else $error("scan limit not the low three bits");
   chk_duty_code: assert property (s_wr(LDC_ADDR_BRIGHT) |=> global_duty ==
      (($past(reg_wr.data[3:0], 2) == 4'hf) ? 5'h0f : {1'b0, $past(reg_wr.data[3:0], 2)} + 5'h01))
      else $error("duty does not match brightness code");
   chk_clear_rise: assert property (clear_digits |-> $past(cs_n) && !$past(cs_n, 2))
      else $error("clear pulse not one edge after chip select rise");
   chk_clear_once: assert property (clear_digits |=> !clear_digits)
      else $error("clear pulse longer than one cycle");
   chk_seg_subset: assert property ((seg_on & ~($past(upper_plane) | $past(lower_plane))) == 16'h0000)
      else $error("segment lit with both plane bits clear");
   chk_both_lit: assert property (display_run && $past(display_run) |->
      ($past(upper_plane) & $past(lower_plane) & ~seg_on) == 16'h0000)
      else $error("segment with both plane bits set is dark");
   chk_reset_vals: assert property (!$past(rstn) |-> scan_last == 3'h7 && global_duty == 5'h01 && !display_run)
      else $error("outputs not at power-up values");
   // config readback bit 7 and the phase output sample the same timer state
   chk_phase_read: assert property ($past(rd_addr) == LDC_ADDR_CONFIG |-> rd_data[7] == blink_phase)
      else $error("readback phase bit differs from phase output");
endmodule : ldc_props
bind ldc_ctrl ldc_props u_props (.sys_clk(sys_clk), .rstn(rstn), .reg_wr(reg_wr),
   .rd_addr(rd_addr), .rd_data(rd_data), .cs_n(cs_n), .upper_plane(upper_plane),
   .lower_plane(lower_plane), .seg_on(seg_on), .display_run(display_run),
   .per_digit_intensity(per_digit_intensity), .global_duty(global_duty),
   .scan_last(scan_last), .clear_digits(clear_digits), .blink_phase(blink_phase));
`default_nettype wire

// *** bench/test_led_display_config_ctrl.sv ***
// self-checking bench for the display control bank
// assumes ldc_host_model plays the host and the checker is bound in
`timescale 1ns/10ps
`default_nettype none
module test_led_display_config_ctrl
   import ldc_pkg::*;
;
   localparam int SLOW = 20; // shortened blink halves
   localparam int FAST = 10;
   logic sys_clk = 1'b0;
   logic rstn = 1'b0;
   logic [15:0] upper_plane = 16'hff00; // all four plane pairs
   logic [15:0] lower_plane = 16'hf0f0;
   ldc_wr_t reg_wr;
   logic [7:0] rd_addr;
   logic [7:0] rd_data;
   logic cs_n;
   logic [15:0] seg_on;
   logic display_run;
   logic per_digit_intensity;
   logic [4:0] global_duty;
   logic [2:0] scan_last;
   logic clear_digits;
   logic blink_phase;
   int failures = 0;
   int checks_done = 0;
   int cycles = 0;
   logic [7:0] rv;
   initial forever #2.5 sys_clk = ~sys_clk;
   ldc_host_model host (.sys_clk(sys_clk), .reg_wr(reg_wr), .rd_addr(rd_addr),
      .cs_n(cs_n), .rd_data(rd_data));
   ldc_ctrl #(.SLOW_HALF_CYC(SLOW), .FAST_HALF_CYC(FAST)) DUT (.sys_clk(sys_clk),
      .rstn(rstn), .reg_wr(reg_wr), .rd_addr(rd_addr), .rd_data(rd_data), .cs_n(cs_n),
      .upper_plane(upper_plane), .lower_plane(lower_plane), .seg_on(seg_on),
      .display_run(display_run), .per_digit_intensity(per_digit_intensity),
      .global_duty(global_duty), .scan_last(scan_last), .clear_digits(clear_digits),
      .blink_phase(blink_phase));
   // ****************************************
   // helpers
   // ****************************************
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         failures++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic wt(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask : wt
   task automatic end_of_test();
      $display("checks=%0d mismatches=%0d", checks_done, failures);
      if (failures == 0 && checks_done > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : end_of_test
   // hang guard
   always @(posedge sys_clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 3000)
      begin
         failures++;
         end_of_test();
      end
   end
   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_reset();
      check(display_run, 1'b0);
      check(seg_on, 16'h0000);
      check(global_duty, 5'h01);
      host.rd(LDC_ADDR_CONFIG, rv);
      check(rv & 8'h7f, 8'h00);
      host.rd(LDC_ADDR_SCAN, rv);
      check(rv[2:0], 3'h7);
   endtask : t_reset
   task automatic t_run();
      host.frame(LDC_ADDR_CONFIG, 8'h01);
      wt(3);
      check(display_run, 1'b1);
      check(seg_on, 16'hf0f0);
      check(per_digit_intensity, 1'b0);
      host.frame(LDC_ADDR_CONFIG, 8'h45); // per-digit, fast, blink off
      wt(3);
      check(per_digit_intensity, 1'b1);
      check(seg_on, 16'hf0f0);
   endtask : t_run
   task automatic t_regs();
      for (int n = 0; n < 16; n++)
      begin
         host.frame(LDC_ADDR_BRIGHT, 8'hf0 | n[7:0]);
         wt(2);
         check(global_duty, (n == 15) ? 5'h0f : n[4:0] + 5'h01);
         if (n < 8)
         begin
            host.frame(LDC_ADDR_SCAN, 8'hf8 | n[7:0]);
            wt(2);
            check(scan_last, n[2:0]);
         end
      end
      host.frame(8'h05, 8'h00); // unmapped write dropped
      host.rd(8'h05, rv);
      check(rv, 8'h00);
      host.rd(LDC_ADDR_BRIGHT, rv);
      check(rv, 8'hff);
      host.rd(LDC_ADDR_SCAN, rv);
      check(rv, 8'hff);
   endtask : t_regs
   task automatic t_blink(input logic [7:0] cfg, input int half);
      host.frame(LDC_ADDR_CONFIG, cfg | 8'h10); // restart blink timer at frame end
      wt(2);
      check(blink_phase, 1'b1);
      host.rd(LDC_ADDR_CONFIG, rv);
      check(rv[7], 1'b1);
      check(seg_on, 16'hf0f0);
      wt(half);
      check(blink_phase, 1'b0);
      check(seg_on, 16'hff00);
      host.rd(LDC_ADDR_CONFIG, rv);
      check(rv[7], 1'b0);
   endtask : t_blink
   task automatic t_clear(input logic [7:0] a, input logic [7:0] d, input int exp);
      int seen;
      seen = 0;
      host.frame(a, d);
      repeat (4)
      begin
         wt(1);
         if (clear_digits === 1'b1)
            seen++;
      end
      check(seen[15:0], exp[15:0]);
   endtask : t_clear
   initial
   begin
      repeat (5) @(posedge sys_clk);
      rstn <= 1'b1;
      wt(1);
      t_reset();
      t_run();
      t_regs();
      t_blink(8'h09, SLOW);
      t_blink(8'h0d, FAST);
      t_clear(LDC_ADDR_CONFIG, 8'h21, 1);
      t_clear(LDC_ADDR_BRIGHT, 8'h00, 0);
      t_clear(LDC_ADDR_CONFIG, 8'h01, 0);
      end_of_test();
   end
endmodule : test_led_display_config_ctrl
`default_nettype wire

// *** core/ldc_blink_timer.sv ***
// blink half-period timer with restart
// assumes a one-cycle restart pulse from the register bank
`timescale 1ns/10ps
`default_nettype none
module ldc_blink_timer
   import ldc_pkg::*;
#(
   parameter int unsigned SLOW_HALF_CYC = LDC_SLOW_HALF_CYC,
   parameter int unsigned FAST_HALF_CYC = LDC_FAST_HALF_CYC
)
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic rstn,
   // control
   input wire logic fast,
   input wire logic restart,
   // state
   output logic phase_first
);

   localparam logic [LDC_CNT_W-1:0] SLOW_LAST = LDC_CNT_W'(SLOW_HALF_CYC - 1);
   localparam logic [LDC_CNT_W-1:0] FAST_LAST = LDC_CNT_W'(FAST_HALF_CYC - 1);

   logic [LDC_CNT_W-1:0] cnt_reg; // cycles into current half
   logic [LDC_CNT_W-1:0] last; // terminal count for rate

   // terminal count follows the selected rate
   always_comb
   begin
      last = fast ? FAST_LAST : SLOW_LAST;
   end

   // half-period counter
   always_ff @(posedge sys_clk)
   begin
      if (!rstn || restart)
      begin
         cnt_reg <= '0;
      end
      else if (cnt_reg >= last)
      begin
         cnt_reg <= '0; // end of half, also when rate shortens
      end
      else
      begin
         cnt_reg <= cnt_reg + 1'b1;
      end
   end

   // phase flag, high in the first half of each period
   always_ff @(posedge sys_clk)
   begin
      if (!rstn || restart)
      begin
         phase_first <= 1'b1;
      end
      else if (cnt_reg >= last)
      begin
         phase_first <= ~phase_first;
      end
   end

endmodule : ldc_blink_timer
`default_nettype wire

// *** core/ldc_ctrl.sv ***
// display control register bank: configuration, scan limit, brightness
// assumes the serial front end hands over decoded writes while chip
// select is low and shows chip select as a synchronous level
`timescale 1ns/10ps
`default_nettype none
module ldc_ctrl
   import ldc_pkg::*;
#(
   parameter int unsigned SLOW_HALF_CYC = LDC_SLOW_HALF_CYC,
   parameter int unsigned FAST_HALF_CYC = LDC_FAST_HALF_CYC
)
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic rstn,
   // register access from serial front end
   input wire ldc_wr_t reg_wr,
   input wire logic [7:0] rd_addr,
   output logic [7:0] rd_data,
   input wire logic cs_n,
   // digit planes of the digit being shown
   input wire logic [LDC_SEG_W-1:0] upper_plane,
   input wire logic [LDC_SEG_W-1:0] lower_plane,
   // display controls
   output logic [LDC_SEG_W-1:0] seg_on,
   output logic display_run,
   output logic per_digit_intensity,
   output logic [LDC_DUTY_W-1:0] global_duty,
   output logic [LDC_SCAN_W-1:0] scan_last,
   output logic clear_digits,
   output logic blink_phase
);

   // ****************************************
   // storage
   // ****************************************
   ldc_cfg_t cfg_reg; // display_configuration fields
   logic [7:0] bright_reg; // global_brightness
   logic [7:0] scan_reg; // digit_scan_limit
   logic cs_n_d_reg; // chip select last cycle
   logic clear_pend_reg; // clear requested in this frame
   logic sync_pend_reg; // restart requested in this frame
   logic cs_rise; // frame end
   logic sync_pulse; // blink restart
   logic phase_first; // first blink half
   logic wr_cfg; // write to configuration
   logic [LDC_SEG_W-1:0] seg_next; // segment drive next value
   logic [LDC_DUTY_W-1:0] duty_next; // duty next value

   // ****************************************
   // write decode
   // ****************************************
   assign wr_cfg = reg_wr.wr && (reg_wr.addr == LDC_ADDR_CONFIG);

   // configuration register
   always_ff @(posedge sys_clk)
   begin
      if (!rstn)
      begin
         cfg_reg <= ldc_cfg_t'({LDC_RST_CONFIG[LDC_BIT_PER_DIGIT:LDC_BIT_FAST],
                                LDC_RST_CONFIG[LDC_BIT_RUN]});
      end
      else if (wr_cfg)
      begin
         cfg_reg.run <= reg_wr.data[LDC_BIT_RUN];
         cfg_reg.fast <= reg_wr.data[LDC_BIT_FAST];
         cfg_reg.blink_en <= reg_wr.data[LDC_BIT_BLINK_EN];
         cfg_reg.sync <= reg_wr.data[LDC_BIT_SYNC];
         cfg_reg.clear <= reg_wr.data[LDC_BIT_CLEAR];
         cfg_reg.per_digit <= reg_wr.data[LDC_BIT_PER_DIGIT];
      end
   end

   // brightness register, whole byte kept for readback
   always_ff @(posedge sys_clk)
   begin
      if (!rstn)
      begin
         bright_reg <= LDC_RST_BRIGHT;
      end
      else if (reg_wr.wr && (reg_wr.addr == LDC_ADDR_BRIGHT))
      begin
         bright_reg <= reg_wr.data;
      end
   end

   // scan limit register, whole byte kept for readback
   always_ff @(posedge sys_clk)
   begin
      if (!rstn)
      begin
         scan_reg <= LDC_RST_SCAN;
      end
      else if (reg_wr.wr && (reg_wr.addr == LDC_ADDR_SCAN))
      begin
         scan_reg <= reg_wr.data;
      end
   end

   // ****************************************
   // frame end actions
   // ****************************************
   // chip select edge detect
   always_ff @(posedge sys_clk)
   begin
      if (!rstn)
      begin
         cs_n_d_reg <= 1'b1;
      end
      else
      begin
         cs_n_d_reg <= cs_n;
      end
   end

   assign cs_rise = cs_n && !cs_n_d_reg;

   // pending clear: a write in the rise cycle wins
   always_ff @(posedge sys_clk)
   begin
      if (!rstn)
      begin
         clear_pend_reg <= 1'b0;
      end
      else if (wr_cfg)
      begin
         clear_pend_reg <= reg_wr.data[LDC_BIT_CLEAR];
      end
      else if (cs_rise)
      begin
         clear_pend_reg <= 1'b0;
      end
   end

   // pending blink restart: a write in the rise cycle wins
   always_ff @(posedge sys_clk)
   begin
      if (!rstn)
      begin
         sync_pend_reg <= 1'b0;
      end
      else if (wr_cfg)
      begin
         sync_pend_reg <= reg_wr.data[LDC_BIT_SYNC];
      end
      else if (cs_rise)
      begin
         sync_pend_reg <= 1'b0;
      end
   end

   // one-cycle clear strobe to the digit memory
   always_ff @(posedge sys_clk)
   begin
      if (!rstn)
      begin
         clear_digits <= 1'b0;
      end
      else
      begin
         clear_digits <= cs_rise && clear_pend_reg;
      end
   end

   assign sync_pulse = cs_rise && sync_pend_reg;

   // ****************************************
   // blink timing
   // ****************************************
   ldc_blink_timer #(
      .SLOW_HALF_CYC(SLOW_HALF_CYC),
      .FAST_HALF_CYC(FAST_HALF_CYC)
   ) u_timer (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .fast(cfg_reg.fast),
      .restart(sync_pulse),
      .phase_first(phase_first)
   );

   // ****************************************
   // segment and intensity drive
   // ****************************************
   always_comb
   begin
      seg_next = '0;
      if (!cfg_reg.run)
      begin
         seg_next = '0; // blanked in shutdown
      end
      else if (!cfg_reg.blink_en)
      begin
         seg_next = lower_plane; // steady lower plane
      end
      else
      begin
         // both set: always on; one set: its half only
         seg_next = (upper_plane & lower_plane) |
                    (phase_first ? lower_plane : upper_plane);
      end
   end

   // duty numerator, code 15 capped at 15/16
   always_comb
   begin
      duty_next = LDC_DUTY_W'(bright_reg[LDC_BRIGHT_W-1:0]) + 1'b1;
      if (duty_next > LDC_DUTY_MAX)
      begin
         duty_next = LDC_DUTY_MAX;
      end
   end

   // registered display controls
   always_ff @(posedge sys_clk)
   begin
      if (!rstn)
      begin
         seg_on <= '0;
         display_run <= 1'b0;
         per_digit_intensity <= 1'b0;
         global_duty <= LDC_DUTY_W'(1);
         scan_last <= LDC_RST_SCAN[LDC_SCAN_W-1:0];
         blink_phase <= 1'b0;
      end
      else
      begin
         seg_on <= seg_next;
         display_run <= cfg_reg.run;
         per_digit_intensity <= cfg_reg.per_digit;
         global_duty <= duty_next;
         scan_last <= scan_reg[LDC_SCAN_W-1:0];
         blink_phase <= phase_first;
      end
   end

   // ****************************************
   // readback
   // ****************************************
   always_ff @(posedge sys_clk)
   begin
      if (!rstn)
      begin
         rd_data <= 8'h00;
      end
      else if (rd_addr == LDC_ADDR_CONFIG)
      begin
         // bit 1 reads zero; bit 7 is live phase
         rd_data <= {phase_first, cfg_reg.per_digit, cfg_reg.clear, cfg_reg.sync,
                     cfg_reg.blink_en, cfg_reg.fast, 1'b0, cfg_reg.run};
      end
      else if (rd_addr == LDC_ADDR_SCAN)
      begin
         rd_data <= scan_reg;
      end
      else if (rd_addr == LDC_ADDR_BRIGHT)
      begin
         rd_data <= bright_reg;
      end
      else
      begin
         rd_data <= 8'h00; // other addresses belong elsewhere
      end
   end

endmodule : ldc_ctrl
`default_nettype wire

// *** core/ldc_pkg.sv ***
// constants, field layout and carrier types of the display control bank
// assumes a serial front end that delivers decoded register writes
package ldc_pkg;

   // ****************************************
   // register addresses
   // ****************************************
   localparam logic [7:0] LDC_ADDR_BRIGHT = 8'h02; // global_brightness
   localparam logic [7:0] LDC_ADDR_SCAN = 8'h03; // digit_scan_limit
   localparam logic [7:0] LDC_ADDR_CONFIG = 8'h04; // display_configuration

   // ****************************************
   // reset values
   // ****************************************
   localparam logic [7:0] LDC_RST_BRIGHT = 8'h00; // 1/16 duty
   localparam logic [7:0] LDC_RST_SCAN = 8'h07; // digits 0..7
   localparam logic [7:0] LDC_RST_CONFIG = 8'h00; // shutdown, slow, no blink

   // ****************************************
   // configuration field positions
   // ****************************************
   localparam int LDC_BIT_RUN = 0;
   localparam int LDC_BIT_FAST = 2;
   localparam int LDC_BIT_BLINK_EN = 3;
   localparam int LDC_BIT_SYNC = 4;
   localparam int LDC_BIT_CLEAR = 5;
   localparam int LDC_BIT_PER_DIGIT = 6;
   localparam int LDC_BIT_PHASE = 7;

   // ****************************************
   // field widths
   // ****************************************
   localparam int LDC_SCAN_W = 3; // scan limit value bits
   localparam int LDC_BRIGHT_W = 4; // intensity code bits
   localparam int LDC_DUTY_W = 5; // duty numerator, sixteenths
   localparam int LDC_SEG_W = 16; // segments per digit
   localparam logic [4:0] LDC_DUTY_MAX = 5'h0f; // 15/16 ceiling

   // ****************************************
   // blink timing
   // ****************************************
   localparam int unsigned LDC_CLK_HZ = 200_000_000; // sys_clk rate
   localparam int unsigned LDC_OSC_HZ = 4_000_000; // rated oscillator
   localparam int unsigned LDC_SLOW_HALF_MS = 1000; // 1s on, 1s off
   localparam int unsigned LDC_FAST_HALF_MS = 500; // 0.5s on, 0.5s off
   localparam int unsigned LDC_SLOW_HALF_CYC = (LDC_CLK_HZ / 1000) * LDC_SLOW_HALF_MS;
   localparam int unsigned LDC_FAST_HALF_CYC = (LDC_CLK_HZ / 1000) * LDC_FAST_HALF_MS;
   localparam int LDC_CNT_W = 28; // holds 2e8

   // ****************************************
   // carrier types
   // ****************************************
   typedef struct packed {
      logic per_digit; // per-digit intensity source
      logic clear; // clear planes at frame end
      logic sync; // restart blink at frame end
      logic blink_en; // blinking enabled
      logic fast; // fast blink rate
      logic run; // normal operation
   } ldc_cfg_t;

   typedef struct packed {
      logic wr; // one-cycle write strobe
      logic [7:0] addr; // register address
      logic [7:0] data; // write data
   } ldc_wr_t;

endpackage : ldc_pkg
